// ### inc/aor_cfg.svh
/*
 * Constants for the audio output router: clock figures, timing counts,
 * register map, field positions and reset values.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef AOR_CFG_SVH
`define AOR_CFG_SVH

`define AOR_CLK_HZ 250000000
`define AOR_NS_PER_S 1000000000
`define AOR_FS_441_HZ 44100
`define AOR_FS_48_HZ 48000
`define AOR_NCO_W 32
`define AOR_LOSS_NS 100000
`define AOR_BLOCK_FRAMES 192

`define AOR_SAMPLE_W 24
`define AOR_GROUPS 4
`define AOR_SRC_CNT 10
`define AOR_SEL_W 4
`define AOR_MT_PAIRS 4
`define AOR_SB_PAIRS 4

`define AOR_SRC_FIRST_PRO 0
`define AOR_SRC_SECOND_PRO 1
`define AOR_SRC_MT_BASE 2
`define AOR_SRC_SB_BASE 6

`define AOR_ADDR_W 12
`define AOR_ADDR_ROUTE 12'h000
`define AOR_ADDR_CLOCK 12'h004
`define AOR_ADDR_FORMAT 12'h008
`define AOR_ADDR_STATUS 12'h00C

`define AOR_CLK_SEL_LSB 0
`define AOR_CLK_SEL_W 3
`define AOR_CLK_RATE_BIT 3
`define AOR_CLK_W 4
`define AOR_FMT_OUT1_BIT 0
`define AOR_FMT_OUT234_BIT 1
`define AOR_FMT_INOPT_BIT 2
`define AOR_FMT_W 3
`define AOR_ST_CLK_LSB 0
`define AOR_ST_FMT_LSB 4
`define AOR_ST_LOST_BIT 6
`define AOR_ST_OPTREJ_BIT 7
`define AOR_ST_ROUTE_LSB 16

`define AOR_ROUTE_RST 16'h9876
`define AOR_CLOCK_RST 4'hD
`define AOR_FORMAT_RST 3'h3

`endif

// ### inc/aor_pkg.sv
/*
 * Types shared by the audio output router files.
 * Assumes aor_cfg.svh is on the include path.
 */
`include "aor_cfg.svh"

package aor_pkg;
    typedef struct packed {
        logic [`AOR_SAMPLE_W-1:0] left;
        logic [`AOR_SAMPLE_W-1:0] right;
    } aor_pair_t;

    typedef enum logic [`AOR_CLK_SEL_W-1:0] {
        AOR_CK_FIRST_PRO,
        AOR_CK_SECOND_PRO,
        AOR_CK_MULTITRACK,
        AOR_CK_STREAM_BUS,
        AOR_CK_WORD_CLOCK,
        AOR_CK_INTERNAL
    } aor_clk_src_t;

    typedef logic [`AOR_SEL_W-1:0] aor_sel_t;
endpackage

// ### rtl/aor_frame_tick.sv
/*
 * Counts master-clock frames into channel status blocks and flags the
 * first frame of each block.
 * Assumes tick is a one-cycle pulse on pclk; restart is a level.
 */
`timescale 1ns/1ps
`include "aor_cfg.svh"

module aor_frame_tick #(
    parameter int BLOCK_FRAMES = `AOR_BLOCK_FRAMES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic restart,
    output logic block_start
);
    import aor_pkg::*;

    localparam int CW = $clog2(BLOCK_FRAMES);
    localparam logic [CW-1:0] LAST = CW'(BLOCK_FRAMES - 1);

    generate
        if (BLOCK_FRAMES < 2) begin : g_bad
            $error("BLOCK_FRAMES must be at least 2");
        end
    endgenerate

    logic [CW-1:0] frame_r;

    // After a loss the next frame opens a fresh block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_r <= '0;
        end else if (restart) begin
            frame_r <= '0;
        end else if (tick) begin
            frame_r <= (frame_r == LAST) ? '0 : frame_r + CW'(1);
        end
    end

    assign block_start = tick && (frame_r == '0);
endmodule

// ### rtl/aor_top.sv
/*
 * Output router and master clock selector: four destination selectors
 * feed the parallel output groups, one master clock times them all.
 * Assumes input pairs arrive already decoded on pclk with one-cycle
 * valid pulses; the word clock pin is asynchronous; APB master.
 */
// Chosen here: the APB interface to the registers and the register offsets.
// Contract
// - Four selectors, each feeds one group
// - Selector one: pro1, optical, multitrack 1-2, A, return
// - Selector two: pro2, multitrack 3-4, pair B
// - Selector three: pro3, multitrack 5-6, pair C
// - Selector four: pro4, multitrack 7-8, pair D
// - Ten identical sources for every selector
// - Group outputs always live, never gated; here all are zeroed while the master is lost
// - Master clock times all outputs, six sources
// - Internal oscillator at 44.1k or 48k
// - Lost master clock: outputs muted
// - Word clock output follows master selector
// - Lost master: word clock output absent
// - First input takes XLR or optical receiver
// - Format bit for output 1, bit for 2-4
// - Format changes channel status only
// - First pro output copied to optical
// - Stream bus out sends pairs A-D only
// - Optical first input accepts consumer framing only
`timescale 1ns/1ps
`include "aor_cfg.svh"

module aor_top #(
    parameter int LOSS_CYC = int'((64'(`AOR_LOSS_NS) * 64'(`AOR_CLK_HZ))
        / 64'(`AOR_NS_PER_S)),
    parameter int BLOCK_FRAMES = `AOR_BLOCK_FRAMES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`AOR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire aor_pkg::aor_pair_t first_pro_xlr_in,
    input wire logic first_pro_xlr_valid,
    input wire aor_pkg::aor_pair_t first_pro_opt_in,
    input wire logic first_pro_opt_valid,
    input wire logic first_pro_opt_pro_frame,
    input wire aor_pkg::aor_pair_t second_pro_in,
    input wire logic second_pro_valid,
    input wire aor_pkg::aor_pair_t multitrack_in [`AOR_MT_PAIRS],
    input wire logic [`AOR_MT_PAIRS-1:0] multitrack_valid,
    input wire aor_pkg::aor_pair_t stream_bus_in [`AOR_SB_PAIRS],
    input wire logic [`AOR_SB_PAIRS-1:0] stream_bus_valid,
    input wire logic word_clock_input,
    output aor_pkg::aor_pair_t pro_out [`AOR_GROUPS],
    output aor_pkg::aor_pair_t first_pro_opt_out,
    output aor_pkg::aor_pair_t multitrack_out [`AOR_MT_PAIRS],
    output aor_pkg::aor_pair_t stream_bus_out [`AOR_SB_PAIRS],
    output aor_pkg::aor_pair_t return_out,
    output logic out_strobe,
    output logic [`AOR_GROUPS-1:0] cs_pro,
    output logic block_start,
    output logic first_pro_opt_sel,
    output logic word_clock_out
);
    import aor_pkg::*;

    localparam int LW = $clog2(LOSS_CYC + 1);
    localparam logic [LW-1:0] LOSS_LAST = LW'(LOSS_CYC);
    localparam int RW = `AOR_GROUPS * `AOR_SEL_W;
    localparam logic [`AOR_NCO_W-1:0] INC_441 = `AOR_NCO_W'(
        (64'(`AOR_FS_441_HZ) << `AOR_NCO_W) / 64'(`AOR_CLK_HZ));
    localparam logic [`AOR_NCO_W-1:0] INC_48 = `AOR_NCO_W'(
        (64'(`AOR_FS_48_HZ) << `AOR_NCO_W) / 64'(`AOR_CLK_HZ));

    generate
        if (LOSS_CYC < 4) begin : g_bad_loss
            $error("LOSS_CYC too small to judge a master clock");
        end
        if (`AOR_SRC_CNT > (1 << `AOR_SEL_W)) begin : g_bad_sel
            $error("Selector field too narrow for the source count");
        end
    endgenerate

    // Register state: software copies and the copies in force
    logic [RW-1:0] route_sw_r;
    logic [RW-1:0] route_act_r;
    logic [`AOR_CLK_W-1:0] clock_sw_r;
    logic [`AOR_CLK_W-1:0] clock_act_r;
    logic [`AOR_FMT_W-1:0] format_sw_r;
    logic [`AOR_FMT_W-1:0] format_act_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // Timing state
    logic [`AOR_NCO_W-1:0] nco_r;
    logic nco_tick;
    logic wc_s1_r;
    logic wc_s2_r;
    logic wc_s3_r;
    logic wc_lvl_r;
    logic wc_rise;
    logic master_tick;
    logic [LW-1:0] idle_r;
    logic lost_r;
    logic [LW-1:0] per_cnt_r;
    logic [LW-1:0] per_r;
    logic wck_out_r;
    logic blk;
    logic blk_r;

    // Audio state
    aor_pair_t src_pair [`AOR_SRC_CNT];
    logic [`AOR_SRC_CNT-1:0] src_valid;
    aor_pair_t hold_r [`AOR_SRC_CNT];
    aor_pair_t grp_r [`AOR_GROUPS];
    logic [`AOR_GROUPS-1:0] cs_pro_r;
    logic strobe_r;
    logic opt_rej;

    // APB
    logic setup;
    logic access;
    logic [`AOR_ADDR_W-1:0] addr;
    logic route_ok;
    logic clock_ok;

    assign setup = psel && !penable;
    assign access = psel && penable && pready_r;
    assign addr = paddr;

    always_comb begin
        route_ok = 1'h1;
        for (int g = 0; g < `AOR_GROUPS; g++) begin
            if (pwdata[g*`AOR_SEL_W +: `AOR_SEL_W] >= `AOR_SEL_W'(`AOR_SRC_CNT))
                route_ok = 1'h0;
        end
        clock_ok = pwdata[`AOR_CLK_SEL_LSB +: `AOR_CLK_SEL_W]
            <= `AOR_CLK_SEL_W'(AOR_CK_INTERNAL);
    end

    // Answer one cycle after setup; illegal codes and holes give an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'h0;
            pslverr_r <= 1'h0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= setup;
            pslverr_r <= 1'h0;
            prdata_r <= 32'h0;
            if (setup) begin
                unique case (addr)
                    `AOR_ADDR_ROUTE: begin
                        prdata_r <= 32'(route_sw_r);
                        pslverr_r <= pwrite && !route_ok;
                    end
                    `AOR_ADDR_CLOCK: begin
                        prdata_r <= 32'(clock_sw_r);
                        pslverr_r <= pwrite && !clock_ok;
                    end
                    `AOR_ADDR_FORMAT: begin
                        prdata_r <= 32'(format_sw_r);
                    end
                    `AOR_ADDR_STATUS: begin
                        prdata_r[`AOR_ST_CLK_LSB +: `AOR_CLK_W] <= clock_act_r;
                        prdata_r[`AOR_ST_FMT_LSB +: `AOR_FMT_W - 1] <=
                            format_act_r[`AOR_FMT_OUT234_BIT:0];
                        prdata_r[`AOR_ST_LOST_BIT] <= lost_r;
                        prdata_r[`AOR_ST_OPTREJ_BIT] <= opt_rej;
                        prdata_r[`AOR_ST_ROUTE_LSB +: RW] <= route_act_r;
                    end
                    default: begin
                        pslverr_r <= 1'h1;
                    end
                endcase
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Software copies; a refused write leaves the old value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_sw_r <= `AOR_ROUTE_RST;
            clock_sw_r <= `AOR_CLOCK_RST;
            format_sw_r <= `AOR_FORMAT_RST;
        end else if (access && pwrite && !pslverr_r) begin
            if (addr == `AOR_ADDR_ROUTE)
                route_sw_r <= pwdata[RW-1:0];
            if (addr == `AOR_ADDR_CLOCK)
                clock_sw_r <= pwdata[`AOR_CLK_W-1:0];
            if (addr == `AOR_ADDR_FORMAT)
                format_sw_r <= pwdata[`AOR_FMT_W-1:0];
        end
    end

    // Copies in force change only at a block start, or freely while the
    // master is lost, so a dead source can never lock the selector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_act_r <= `AOR_ROUTE_RST;
            clock_act_r <= `AOR_CLOCK_RST;
            format_act_r <= `AOR_FORMAT_RST;
        end else if (blk || lost_r) begin
            route_act_r <= route_sw_r;
            clock_act_r <= clock_sw_r;
            format_act_r <= format_sw_r;
        end
    end

    // The receiver choice is not framed, it only picks a wire
    assign first_pro_opt_sel = format_sw_r[`AOR_FMT_INOPT_BIT];

    // Optical receiver refuses professional framing
    assign opt_rej = first_pro_opt_sel && first_pro_opt_pro_frame;

    // Source table, same for every selector
    always_comb begin
        src_pair[`AOR_SRC_FIRST_PRO] = first_pro_opt_sel ?
            first_pro_opt_in : first_pro_xlr_in;
        src_valid[`AOR_SRC_FIRST_PRO] = first_pro_opt_sel ?
            (first_pro_opt_valid && !first_pro_opt_pro_frame)
            : first_pro_xlr_valid;
        src_pair[`AOR_SRC_SECOND_PRO] = second_pro_in;
        src_valid[`AOR_SRC_SECOND_PRO] = second_pro_valid;
        for (int p = 0; p < `AOR_MT_PAIRS; p++) begin
            src_pair[`AOR_SRC_MT_BASE + p] = multitrack_in[p];
            src_valid[`AOR_SRC_MT_BASE + p] = multitrack_valid[p];
        end
        for (int p = 0; p < `AOR_SB_PAIRS; p++) begin
            src_pair[`AOR_SRC_SB_BASE + p] = stream_bus_in[p];
            src_valid[`AOR_SRC_SB_BASE + p] = stream_bus_valid[p];
        end
    end

    // Latest sample of each source, re-timed to the master frame
    generate
        for (genvar i = 0; i < `AOR_SRC_CNT; i++) begin : g_hold
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    hold_r[i] <= '0;
                else if (src_valid[i])
                    hold_r[i] <= src_pair[i];
            end
        end
    endgenerate

    // Internal oscillator as a phase accumulator; rate fixed by one bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            nco_r <= '0;
        else
            nco_r <= nco_r + (clock_act_r[`AOR_CLK_RATE_BIT] ?
                INC_48 : INC_441);
    end

    assign nco_tick = (nco_r + (clock_act_r[`AOR_CLK_RATE_BIT] ?
        INC_48 : INC_441)) < nco_r;

    // Word clock pin: a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wc_s1_r <= 1'h0;
            wc_s2_r <= 1'h0;
            wc_s3_r <= 1'h0;
            wc_lvl_r <= 1'h0;
        end else begin
            wc_s1_r <= word_clock_input;
            wc_s2_r <= wc_s1_r;
            wc_s3_r <= wc_s2_r;
            if (wc_s2_r == wc_s3_r)
                wc_lvl_r <= wc_s3_r;
        end
    end

    assign wc_rise = (wc_s2_r == wc_s3_r) && wc_s3_r && !wc_lvl_r;

    // Master clock selector
    always_comb begin
        unique case (aor_clk_src_t'(clock_act_r[`AOR_CLK_SEL_LSB +:
            `AOR_CLK_SEL_W]))
            AOR_CK_FIRST_PRO: master_tick = src_valid[`AOR_SRC_FIRST_PRO];
            AOR_CK_SECOND_PRO: master_tick = second_pro_valid;
            AOR_CK_MULTITRACK: master_tick = multitrack_valid[0];
            AOR_CK_STREAM_BUS: master_tick = stream_bus_valid[0];
            AOR_CK_WORD_CLOCK: master_tick = wc_rise;
            AOR_CK_INTERNAL: master_tick = nco_tick;
            default: master_tick = 1'h0;
        endcase
    end

    // Loss watchdog; the period is kept for the word clock shape
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_r <= '0;
            lost_r <= 1'h1;
            per_cnt_r <= '0;
            per_r <= '0;
        end else if (master_tick) begin
            idle_r <= '0;
            lost_r <= 1'h0;
            per_cnt_r <= '0;
            per_r <= per_cnt_r;
        end else begin
            if (idle_r != LOSS_LAST)
                idle_r <= idle_r + LW'(1);
            else
                lost_r <= 1'h1;
            if (per_cnt_r != LOSS_LAST)
                per_cnt_r <= per_cnt_r + LW'(1);
        end
    end

    aor_frame_tick #(
        .BLOCK_FRAMES(BLOCK_FRAMES)
    ) u_frame (
        .pclk(pclk),
        .presetn(presetn),
        .tick(master_tick),
        .restart(lost_r),
        .block_start(blk)
    );

    // Every group takes its pair on the same master frame; no enable
    // gates an output, so spare outputs double as monitor taps
    generate
        for (genvar g = 0; g < `AOR_GROUPS; g++) begin : g_grp
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    grp_r[g] <= '0;
                end else if (lost_r) begin
                    grp_r[g] <= '0;
                end else if (master_tick) begin
                    grp_r[g] <= hold_r[route_act_r[g*`AOR_SEL_W +:
                        `AOR_SEL_W]];
                end
            end
            assign pro_out[g] = grp_r[g];
            assign multitrack_out[g] = grp_r[g];
            assign stream_bus_out[g] = grp_r[g];
        end
    endgenerate

    assign first_pro_opt_out = grp_r[0];
    assign return_out = grp_r[0];

    // Format only steers the status flags, never an output enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_pro_r <= '0;
            strobe_r <= 1'h0;
            blk_r <= 1'h0;
        end else begin
            cs_pro_r[0] <= format_act_r[`AOR_FMT_OUT1_BIT];
            for (int g = 1; g < `AOR_GROUPS; g++)
                cs_pro_r[g] <= format_act_r[`AOR_FMT_OUT234_BIT];
            strobe_r <= master_tick && !lost_r;
            blk_r <= blk && !lost_r;
        end
    end

    assign cs_pro = cs_pro_r;
    assign out_strobe = strobe_r;
    assign block_start = blk_r;

    // Word clock out: echo of the pin, else high for half a frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wck_out_r <= 1'h0;
        end else if (lost_r) begin
            wck_out_r <= 1'h0;
        end else if (clock_act_r[`AOR_CLK_SEL_LSB +: `AOR_CLK_SEL_W] ==
            `AOR_CLK_SEL_W'(AOR_CK_WORD_CLOCK)) begin
            wck_out_r <= wc_lvl_r;
        end else if (master_tick) begin
            wck_out_r <= 1'h1;
        end else if (per_cnt_r >= (per_r >> 1)) begin
            wck_out_r <= 1'h0;
        end
    end

    assign word_clock_out = wck_out_r;
endmodule

// ### testbench/aor_top_props.sv
/*
 * Checker for the audio output router top: APB answer timing and the
 * parallel copies of each output group.
 * Assumes it is bound to aor_top and sees only its ports.
 */
`timescale 1ns/1ps
`include "aor_cfg.svh"

module aor_top_props
    import aor_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire aor_pkg::aor_pair_t pro_out [`AOR_GROUPS],
    input wire aor_pkg::aor_pair_t first_pro_opt_out,
    input wire aor_pkg::aor_pair_t multitrack_out [`AOR_MT_PAIRS],
    input wire aor_pkg::aor_pair_t stream_bus_out [`AOR_SB_PAIRS],
    input wire aor_pkg::aor_pair_t return_out,
    input wire logic out_strobe,
    input wire logic block_start
);
    logic par_ok;

    // All groups at once, so one stuck copy anywhere fails
    always_comb begin
        par_ok = 1'h1;
        for (int g = 0; g < `AOR_GROUPS; g++) begin
            if (multitrack_out[g] != pro_out[g] ||
                stream_bus_out[g] != pro_out[g])
                par_ok = 1'h0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_setup;
        psel && !penable;
    endsequence

    sequence ready_pulse;
        pready ##1 !pready;
    endsequence

    apb_ack_a: assert property (apb_setup |=> ready_pulse)
        else $error("no single ready pulse after setup");
    ready_place_a: assert property (pready |->
        psel && penable && $past(psel && !penable))
        else $error("ready outside an access cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access cycle");
    group_par_a: assert property (par_ok)
        else $error("group outputs differ");
    opt_copy_a: assert property (first_pro_opt_out == pro_out[0] &&
        return_out == pro_out[0])
        else $error("optical or return copy differs");
    block_strobe_a: assert property (block_start |-> out_strobe)
        else $error("block start without strobe");
    hold_tick_a: assert property ($changed(pro_out[0]) |->
        out_strobe || pro_out[0] == 48'h0)
        else $error("output moved between master ticks");
endmodule

// ### testbench/aor_src_model.sv
/*
 * Partner model: instruments and recorders feeding the audio inputs
 * and the word clock pin.
 * Assumes pclk runs free; en from the bench starts and stops all.
 */
`timescale 1ns/1ps
`include "aor_cfg.svh"

module aor_src_model
    import aor_pkg::*;
(
    input wire logic pclk,
    input wire logic en,
    input wire logic [7:0] epoch,
    output aor_pkg::aor_pair_t xlr,
    output logic xlr_v,
    output aor_pkg::aor_pair_t opt,
    output logic opt_v,
    output aor_pkg::aor_pair_t pro2,
    output logic pro2_v,
    output aor_pkg::aor_pair_t mt [4],
    output logic [3:0] mt_v,
    output aor_pkg::aor_pair_t sb [4],
    output logic [3:0] sb_v,
    output logic wclk
);
    // Periods differ so the chosen master shows in the strobe gap
    localparam int PER [5] = '{20, 24, 28, 32, 18};
    int cnt [5] = '{default: 1};
    logic wclk_r = 1'h0;

    function automatic aor_pair_t mk(input logic [7:0] e,
                                     input logic [3:0] s);
        mk.left = {e, s, 12'hA5A};
        mk.right = ~mk.left;
    endfunction

    always @(posedge pclk)
        for (int i = 0; i < 5; i++)
            if (en)
                cnt[i] <= cnt[i] == PER[i] - 1 ? 0 : cnt[i] + 1;

    // Word clock stands still while stopped
    always @(posedge pclk)
        if (en && cnt[4] == 0)
            wclk_r <= ~wclk_r;

    assign wclk = wclk_r;
    assign xlr_v = en && cnt[0] == 0;
    assign opt_v = xlr_v;
    assign pro2_v = en && cnt[1] == 0;
    assign mt_v = {4{en && cnt[2] == 0}};
    assign sb_v = {4{en && cnt[3] == 0}}; // fixed rate, scaled
    // Data is inverted between pulses so stale samples cannot pass
    assign xlr = xlr_v ? mk(epoch, 4'h0) : ~mk(epoch, 4'h0);
    assign opt = opt_v ? mk(epoch, 4'hF) : ~mk(epoch, 4'hF);
    assign pro2 = pro2_v ? mk(epoch, 4'h1) : ~mk(epoch, 4'h1);
    for (genvar i = 0; i < 4; i++) begin : g_pairs
        assign mt[i] = mt_v[i] ? mk(epoch, 4'(2 + i)) : ~mk(epoch, 4'(2 + i));
        assign sb[i] = sb_v[i] ? mk(epoch, 4'(6 + i)) : ~mk(epoch, 4'(6 + i));
    end
endmodule

// ### testbench/tb.sv
/*
 * Testbench for the audio output router: registers, routing, master
 * clock, formats, word clock and loss of the master.
 * Assumes the partner model feeds every audio input.
 */
`timescale 1ns/1ps
`include "aor_cfg.svh"

module tb;
    import aor_pkg::*;
    localparam int BF = 4;
    localparam int LOSS = 6000;
    localparam int E48 = `AOR_CLK_HZ / `AOR_FS_48_HZ;
    localparam int E44 = `AOR_CLK_HZ / `AOR_FS_441_HZ;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, en = 1, opt_pro = 0, o;
    logic [7:0] epoch = 0;
    logic [15:0] r;
    aor_pair_t xlr, opt, pro2, mt [4], sb [4], pro [4], mt_o [4], sb_o [4];
    aor_pair_t opt_o, ret;
    logic xlr_v, opt_v, pro2_v, wclk_i, strobe, bstart, optsel, wclk_o;
    logic [3:0] mt_v, sb_v, cs;
    logic [32:0] qr [$];
    aor_pair_t qa [$];
    int mismatches = 0, num_checks = 0, seed = 31, n, s;

    always #2 pclk = ~pclk;

    aor_src_model aor_src_model_inst (.pclk(pclk), .en(en), .epoch(epoch),
        .xlr(xlr), .xlr_v(xlr_v), .opt(opt), .opt_v(opt_v), .pro2(pro2),
        .pro2_v(pro2_v), .mt(mt), .mt_v(mt_v), .sb(sb), .sb_v(sb_v),
        .wclk(wclk_i));

    aor_top #(.LOSS_CYC(LOSS), .BLOCK_FRAMES(BF)) aor_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .first_pro_xlr_in(xlr),
        .first_pro_xlr_valid(xlr_v), .first_pro_opt_in(opt),
        .first_pro_opt_valid(opt_v), .first_pro_opt_pro_frame(opt_pro),
        .second_pro_in(pro2), .second_pro_valid(pro2_v),
        .multitrack_in(mt), .multitrack_valid(mt_v), .stream_bus_in(sb),
        .stream_bus_valid(sb_v), .word_clock_input(wclk_i),
        .pro_out(pro), .first_pro_opt_out(opt_o), .multitrack_out(mt_o),
        .stream_bus_out(sb_o), .return_out(ret), .out_strobe(strobe),
        .cs_pro(cs), .block_start(bstart), .first_pro_opt_sel(optsel),
        .word_clock_out(wclk_o));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Read data only matters on reads; writes report just the error bit
    always @(posedge pclk) begin
        if (psel && penable && pready && qr.size() > 0)
            chk({pslverr, pwrite ? 32'h0 : prdata}, qr.pop_front());
        if (strobe && qa.size() > 0)
            for (int g = 0; g < 4; g++)
                chk(pro[g], qa.pop_front());
    end

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        qr.push_back(e);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic ws(input int k);
        repeat (k) do @(posedge pclk); while (strobe !== 1'h1);
    endtask

    task automatic gap(output int c);
        ws(1);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (strobe !== 1'h1);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge pclk);
        mismatches++;
        end_sim;
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        apb(0, 12'h000, 0, 33'h0_0000_9876);
        apb(0, 12'h004, 0, 33'h0_0000_000D);
        apb(0, 12'h008, 0, 33'h0_0000_0003);
        apb(0, 12'h00C, 0, 33'h0_9876_007D);
        apb(0, 12'h010, 0, 33'h1_0000_0000);
        // Still lost, so the new master applies at once
        apb(1, 12'h004, 32'h2, 33'h0);
        apb(1, 12'h000, 32'hA0, 33'h1_0000_0000);
        apb(1, 12'h004, 32'h6, 33'h1_0000_0000);
        apb(0, 12'h000, 0, 33'h0_0000_9876);
        apb(0, 12'h004, 0, 33'h0_0000_0002);
        chk(cs, 4'hF);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            apb(1, 12'h004, k, 33'h0);
            ws(BF + 2);
            gap(n);
            chk(n, 20 + 4 * k);
        end
        $display("test clock sources done");
        for (int k = 0; k < 3; k++) begin
            epoch <= 8'($random(seed));
            o = k == 2;
            for (int g = 0; g < 4; g++)
                r[4*g+:4] = 4'((4 * k + g) % 10);
            apb(1, 12'h008, {o, 2'h3}, 33'h0);
            apb(1, 12'h000, r, 33'h0);
            ws(2 * BF + 2);
            @(negedge pclk);
            chk(optsel, o);
            for (int g = 0; g < 4; g++) begin
                s = r[4*g+:4];
                qa.push_back(aor_src_model_inst.mk(epoch,
                    s == 0 && o ? 4'hF : 4'(s)));
            end
            ws(1);
        end
        opt_pro <= 1'h1;
        apb(0, 12'h00C, 0, 33'h0_1098_00B3);
        opt_pro <= 1'h0;
        $display("test routing done");
        for (int f = 0; f < 4; f++) begin
            apb(1, 12'h008, f, 33'h0);
            ws(2 * BF + 2);
            chk(cs, {{3{f[1]}}, f[0]});
        end
        $display("test formats done");
        apb(1, 12'h004, 32'h4, 33'h0);
        ws(BF + 2);
        @(posedge wclk_i);
        repeat (8) @(posedge pclk);
        chk(wclk_o, 1'h1);
        @(negedge wclk_i);
        repeat (8) @(posedge pclk);
        chk(wclk_o, 1'h0);
        $display("test word clock done");
        en <= 1'h0;
        repeat (LOSS + 40) @(posedge pclk);
        chk(pro[0], 48'h0);
        chk(wclk_o, 1'h0);
        apb(1, 12'h004, 32'hD, 33'h0);
        gap(n);
        chk(n >= E48 - 2 && n <= E48 + 2, 1'h1);
        chk(wclk_o, 1'h1);
        apb(1, 12'h004, 32'h5, 33'h0);
        ws(BF + 2);
        gap(n);
        chk(n >= E44 - 2 && n <= E44 + 2, 1'h1);
        $display("test lost and internal done");
        end_sim;
    end
endmodule

bind aor_top aor_top_props aor_top_props_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pro_out(pro_out),
    .first_pro_opt_out(first_pro_opt_out), .multitrack_out(multitrack_out),
    .stream_bus_out(stream_bus_out), .return_out(return_out),
    .out_strobe(out_strobe), .block_start(block_start));
